// >>> pkg/sdp_pkg.sv
// package: constants and types of the single-wire debug port
package sdp_pkg;
  // ----------------------------------------------------------------
  // clock and timing
  // ----------------------------------------------------------------
  localparam int SYS_CLK_HZ = 20_000_000;
  localparam int DEF_BIT_NS = 8000;
  localparam int DEF_BIT_CYC = (DEF_BIT_NS * (SYS_CLK_HZ / 1_000_000)) / 1000;
  localparam int CNT_W = 16;
  localparam logic [CNT_W-1:0] RST_BIT_CYC = CNT_W'(DEF_BIT_CYC);
  localparam int LOW_W = 20;
  localparam int FRAME_BITS = 12;
  localparam int BREAK_BITS = 12;
  localparam int SYNC_FALLS = 4;
  // ----------------------------------------------------------------
  // pin, fuse and clock select encodings
  // ----------------------------------------------------------------
  localparam logic [1:0] CLKSEL_DEFAULT = 2'h3;
  localparam logic [1:0] FUSE_DEBUG = 2'h1;
  localparam int ADDR_W = 16;
  localparam logic [7:0] ACK_CHAR = 8'h40;
  // ----------------------------------------------------------------
  // instruction set
  // ----------------------------------------------------------------
  localparam logic [2:0] OP_LD = 3'h0;
  localparam logic [2:0] OP_ST = 3'h1;
  localparam logic [2:0] OP_LDCS = 3'h2;
  localparam logic [2:0] OP_STCS = 3'h3;
  localparam logic [3:0] CS_CTRL = 4'h0;
  localparam logic [3:0] CS_FLOW = 4'h1;
  localparam logic [3:0] CS_OCD = 4'h2;
  localparam logic [3:0] CS_NVM = 4'h3;
  localparam logic [3:0] CS_SYS = 4'h4;
  localparam logic [3:0] CS_PCL = 4'h5;
  localparam logic [3:0] CS_PCH = 4'h6;
  localparam logic [3:0] CS_SPL = 4'h7;
  localparam logic [3:0] CS_SPH = 4'h8;
  localparam logic [3:0] CS_SREG = 4'h9;
  localparam logic [3:0] CS_ERR = 4'ha;
  localparam logic [3:0] CS_EVL = 4'hb;
  localparam logic [3:0] CS_EVH = 4'hc;
  localparam logic [2:0] ERR_PARITY = 3'h1;
  localparam logic [2:0] ERR_FRAME = 3'h2;
  localparam logic [2:0] ERR_BUS = 3'h3;
  localparam logic [2:0] ERR_OPCODE = 3'h4;
  localparam int FIFO_W = 8;
  localparam int FIFO_DEPTH = 32;
  // ----------------------------------------------------------------
  // state types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {R_IDLE, R_SYNC, R_BITS} sdp_rx_t;
  typedef enum logic [2:0] {D_SYNC, D_INSTR, D_ARG, D_BUS, D_REPLY,
                            D_ERR} sdp_dec_t;
  typedef enum logic [1:0] {A_IDLE, A_BUS, A_DONE} sdp_acc_t;
endpackage

// >>> logic/sdp_port.sv
// single-wire debug port: physical layer, access layer and reply fifo
`timescale 1ns/1ps

// ------------------------------------------------------------------
// reply fifo
// ------------------------------------------------------------------
module sdp_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
  } sdp_fifo_t;
  sdp_fifo_t q, d;
  logic push, pop;

  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1) begin
    $error("fifo depth must be a power of two");
  end

  assign inReady = q.cnt != (AW + 1)'(DEPTH);
  assign outValid = q.cnt != '0;
  assign outData = q.mem[q.rp];
  assign push = inValid && inReady;
  assign pop = outValid && outReady;

  always_comb begin
    d = q;
    if (push) begin
      d.mem[q.wp] = inData;
      d.wp = q.wp + 1'b1;
    end
    if (pop) begin
      d.rp = q.rp + 1'b1;
    end
    d.cnt = q.cnt + (AW + 1)'(push) - (AW + 1)'(pop);
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end
endmodule

// Operation
// - all traffic is half-duplex uart frames on the one reset pin
// - physical and access layers meet only through a sync handshake
// - newly enabled port starts its physical clock at the 4 MHz default
// - while enabled, physical clock changes only on a write of the clock select field
// - pin becomes debug port on high-voltage pulse or debug fuse setting
// - active port drives pull-up, input and output enables of the pin
// - physical layer keeps running and takes traffic in every sleep mode
// - bus reads and writes are refused while the cpu clock is stopped
// - port can be enabled at any time whatever the sleep state
// - status interface reads debug, nvm and system status without the bus
// - access layer is a system bus master for memory-mapped access
// - accesses reach the whole data space, nvm regions via controller
// - debugger can run, halt, reset and single-step the cpu
// - pc, stack pointer and status register readable at run time
// - crc and sleep status observable without touching system registers
// - communication errors are detected and kept as a readable signature
// - event inputs are counted so oscillator frequencies can be measured
// - only the reset pin is used, no general-purpose pin
// - frame: start, eight data, even parity, two stops; bad bits flagged
// - sync character 0x55 before each instruction sets the bit rate
// - twelve low bit times return receiver and decoder to waiting for sync and drop any access request
// - acknowledge is sent once a store has gained the bus
module sdp_port #(
  parameter int FIFO_DEPTH = sdp_pkg::FIFO_DEPTH
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic padIn,
  output logic padOut,
  output logic padOe,
  output logic padPullUpEn,
  output logic padInputEn,
  output logic resetFuncEn,
  input wire logic hvPulse,
  input wire logic [1:0] resetPinFuse,
  output logic portActive,
  output logic [1:0] physClkSel,
  input wire logic cpuClkOff,
  output logic busReq,
  output logic busWe,
  output logic [sdp_pkg::ADDR_W-1:0] busAddr,
  output logic [7:0] busWdata,
  input wire logic busGrant,
  input wire logic [7:0] busRdata,
  output logic [3:0] cpuCtl,
  input wire logic [7:0] ocdStatus,
  input wire logic [7:0] nvmStatus,
  input wire logic crcStatus,
  input wire logic sleepStatus,
  input wire logic [15:0] cpuPc,
  input wire logic [15:0] cpuSp,
  input wire logic [7:0] cpuSreg,
  output logic [2:0] errSig,
  input wire logic evIn
);
  import sdp_pkg::*;

  typedef struct packed {
    logic active;
    logic hvSeen;
    logic [1:0] clkSel;
    logic prevIn;
    sdp_rx_t rx;
    logic [CNT_W-1:0] cnt;
    logic [2:0] edges;
    logic [CNT_W-1:0] bitLen;
    logic [CNT_W-1:0] tmr;
    logic [3:0] bitIdx;
    logic [11:0] rxSh;
    logic [LOW_W-1:0] lowCnt;
    sdp_dec_t dec;
    logic [2:0] op;
    logic [3:0] fld;
    logic [1:0] argCnt;
    logic [ADDR_W-1:0] addr;
    logic [7:0] wdata;
    logic [7:0] reply;
    logic [2:0] errSig;
    logic accReq;
    sdp_acc_t acc;
    logic busReq;
    logic [7:0] rdata;
    logic accErr;
    logic txBusy;
    logic [11:0] txSh;
    logic [CNT_W-1:0] txTmr;
    logic [3:0] txIdx;
    logic [3:0] cpuCtl;
    logic evPrev;
    logic [15:0] evCnt;
  } sdp_state_t;

  sdp_state_t q, d;
  logic fall, syncDone, rxByte, rxErr, brk, csWrite, accDone;
  logic [11:0] fr;
  logic [7:0] rxData, csRd;
  logic [LOW_W-1:0] brkLen;
  logic fifoInReady, fifoOutValid, fifoOutReady;
  logic [7:0] fifoOutData;

  // ----------------------------------------------------------------
  // reply path: decoder stalls in D_REPLY while the fifo is full
  // ----------------------------------------------------------------
  sdp_fifo #(.WIDTH(FIFO_W), .DEPTH(FIFO_DEPTH)) replyFifo (
    .clk(sys_clk),
    .rst(rst),
    .inValid(q.dec == D_REPLY),
    .inReady(fifoInReady),
    .inData(q.reply),
    .outValid(fifoOutValid),
    .outReady(fifoOutReady),
    .outData(fifoOutData)
  );

  // half duplex: no transmit start while a frame is being received
  assign fifoOutReady = !q.txBusy && q.rx == R_IDLE && q.active;
  assign fr = {padIn, q.rxSh[11:1]};
  assign rxData = fr[8:1];
  assign brkLen = LOW_W'(q.bitLen) * LOW_W'(BREAK_BITS);
  assign accDone = q.acc == A_DONE;

  // ----------------------------------------------------------------
  // status interface, read without the system bus
  // ----------------------------------------------------------------
  always_comb begin
    if (rxData[3:0] == CS_CTRL) begin
      csRd = {6'h0, q.clkSel};
    end else if (rxData[3:0] == CS_OCD) begin
      csRd = ocdStatus;
    end else if (rxData[3:0] == CS_NVM) begin
      csRd = nvmStatus;
    end else if (rxData[3:0] == CS_SYS) begin
      csRd = {6'h0, crcStatus, sleepStatus};
    end else if (rxData[3:0] == CS_PCL) begin
      csRd = cpuPc[7:0];
    end else if (rxData[3:0] == CS_PCH) begin
      csRd = cpuPc[15:8];
    end else if (rxData[3:0] == CS_SPL) begin
      csRd = cpuSp[7:0];
    end else if (rxData[3:0] == CS_SPH) begin
      csRd = cpuSp[15:8];
    end else if (rxData[3:0] == CS_SREG) begin
      csRd = cpuSreg;
    end else if (rxData[3:0] == CS_ERR) begin
      csRd = {5'h0, q.errSig};
    end else if (rxData[3:0] == CS_EVL) begin
      csRd = q.evCnt[7:0];
    end else if (rxData[3:0] == CS_EVH) begin
      csRd = q.evCnt[15:8];
    end else begin
      csRd = 8'h00;
    end
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    d = q;
    d.cpuCtl = 4'h0;
    syncDone = 1'b0;
    rxByte = 1'b0;
    rxErr = 1'b0;
    csWrite = 1'b0;
    fall = q.prevIn && !padIn;
    d.prevIn = padIn;
    // enable is not gated by any sleep signal
    d.hvSeen = q.hvSeen || hvPulse;
    d.active = d.hvSeen || resetPinFuse == FUSE_DEBUG;
    if (d.active && !q.active) begin
      d.clkSel = CLKSEL_DEFAULT;
    end
    // break detection counts low cycles while not driving
    if (!q.active || padIn || q.txBusy) begin
      d.lowCnt = '0;
    end else if (q.lowCnt != '1) begin
      d.lowCnt = q.lowCnt + 1'b1;
    end
    brk = q.active && !q.txBusy && !padIn && q.lowCnt == brkLen - 1'b1;
    // receiver, never stopped by sleep
    case (q.rx)
      R_IDLE: begin
        if (q.active && !q.txBusy && fall) begin
          if (q.dec == D_SYNC) begin
            d.rx = R_SYNC;
            d.cnt = CNT_W'(1);
            d.edges = 3'h0;
          end else begin
            d.rx = R_BITS;
            d.tmr = q.bitLen >> 1;
            d.bitIdx = 4'h0;
          end
        end
      end
      R_SYNC: begin
        // 0x55 gives five falling edges spanning eight bit times
        d.cnt = q.cnt + 1'b1;
        if (fall) begin
          d.edges = q.edges + 1'b1;
          if (q.edges == 3'(SYNC_FALLS - 1)) begin
            d.bitLen = q.cnt >> 3;
            d.rx = R_IDLE;
            syncDone = 1'b1;
          end
        end
      end
      default: begin
        if (q.tmr == '0) begin
          d.rxSh = fr;
          d.tmr = q.bitLen - 1'b1;
          d.bitIdx = q.bitIdx + 1'b1;
          if (q.bitIdx == 4'(FRAME_BITS - 1)) begin
            d.rx = R_IDLE;
            rxErr = fr[0] || (^fr[9:1]) || !(&fr[11:10]);
            rxByte = !rxErr;
            d.errSig = (^fr[9:1]) ? ERR_PARITY : ERR_FRAME;
            if (!rxErr) begin
              d.errSig = q.errSig;
            end
          end
        end else begin
          d.tmr = q.tmr - 1'b1;
        end
      end
    endcase
    // instruction decoder on the physical side
    case (q.dec)
      D_SYNC: begin
        if (syncDone) begin
          d.dec = D_INSTR;
        end
      end
      D_INSTR: begin
        if (rxByte) begin
          d.op = rxData[7:5];
          d.fld = rxData[3:0];
          d.argCnt = 2'h0;
          if (rxData[7:5] == OP_LDCS) begin
            d.reply = csRd;
            d.dec = D_REPLY;
          end else if (rxData[7:5] == OP_LD || rxData[7:5] == OP_ST ||
                       rxData[7:5] == OP_STCS) begin
            d.dec = D_ARG;
          end else begin
            d.errSig = ERR_OPCODE;
            d.dec = D_ERR;
          end
        end
      end
      D_ARG: begin
        if (rxByte) begin
          d.argCnt = q.argCnt + 1'b1;
          if (q.op == OP_STCS) begin
            csWrite = 1'b1;
            d.dec = D_SYNC;
          end else begin
            if (q.argCnt == 2'h0) begin
              d.addr[15:8] = rxData;
            end else if (q.argCnt == 2'h1) begin
              d.addr[7:0] = rxData;
            end else begin
              d.wdata = rxData;
            end
            if (q.argCnt == 2'h2 || (q.op == OP_LD && q.argCnt == 2'h1)) begin
              d.accReq = 1'b1;
              d.dec = D_BUS;
            end
          end
        end
      end
      D_BUS: begin
        if (accDone) begin
          d.accReq = 1'b0;
          if (q.accErr) begin
            d.errSig = ERR_BUS;
            d.dec = D_ERR;
          end else begin
            d.reply = (q.op == OP_LD) ? q.rdata : ACK_CHAR;
            d.dec = D_REPLY;
          end
        end
      end
      D_REPLY: begin
        if (fifoInReady) begin
          d.dec = D_SYNC;
        end
      end
      default: begin
      end
    endcase
    if (csWrite && q.fld == CS_CTRL) begin
      d.clkSel = rxData[1:0];
    end
    if (csWrite && q.fld == CS_FLOW) begin
      d.cpuCtl = rxData[3:0];
    end
    if (rxErr) begin
      d.dec = D_ERR;
      d.accReq = 1'b0;
    end
    if (brk) begin
      d.rx = R_IDLE;
      d.dec = D_SYNC;
      d.accReq = 1'b0;
    end
    // access layer: bus master, one request at a time
    case (q.acc)
      A_IDLE: begin
        if (q.accReq) begin
          if (cpuClkOff) begin
            d.accErr = 1'b1;
            d.acc = A_DONE;
          end else begin
            d.accErr = 1'b0;
            d.busReq = 1'b1;
            d.acc = A_BUS;
          end
        end
      end
      A_BUS: begin
        if (busGrant) begin
          d.busReq = 1'b0;
          d.rdata = busRdata;
          d.acc = A_DONE;
        end
      end
      default: begin
        if (!q.accReq) begin
          d.acc = A_IDLE;
        end
      end
    endcase
    // transmitter: start, data lsb first, even parity, two stops
    if (!q.txBusy) begin
      if (fifoOutValid && fifoOutReady) begin
        d.txBusy = 1'b1;
        d.txSh = {2'b11, ^fifoOutData, fifoOutData, 1'b0};
        d.txTmr = q.bitLen - 1'b1;
        d.txIdx = 4'h0;
      end
    end else if (q.txTmr == '0) begin
      d.txSh = {1'b1, q.txSh[11:1]};
      d.txTmr = q.bitLen - 1'b1;
      d.txIdx = q.txIdx + 1'b1;
      if (q.txIdx == 4'(FRAME_BITS - 1)) begin
        d.txBusy = 1'b0;
      end
    end else begin
      d.txTmr = q.txTmr - 1'b1;
    end
    d.evPrev = evIn;
    if (evIn && !q.evPrev) begin
      d.evCnt = q.evCnt + 1'b1;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      q <= '0;
      q.clkSel <= CLKSEL_DEFAULT;
      q.prevIn <= 1'b1;
      q.bitLen <= RST_BIT_CYC;
      q.txSh <= 12'hfff;
    end else begin
      q <= d;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign padOut = q.txSh[0];
  assign padOe = q.txBusy;
  assign padPullUpEn = q.active;
  assign padInputEn = q.active;
  assign resetFuncEn = !q.active;
  assign portActive = q.active;
  assign physClkSel = q.clkSel;
  assign busReq = q.busReq;
  assign busWe = q.op == OP_ST;
  assign busAddr = q.addr;
  assign busWdata = q.wdata;
  assign cpuCtl = q.cpuCtl;
  assign errSig = q.errSig;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);

  chk_ack_after_grant: assert property (
    (q.acc == A_BUS && busGrant && q.op == OP_ST && q.dec == D_BUS)
    |-> ##2 (q.dec == D_REPLY && q.reply == ACK_CHAR))
    else $error("ack not queued after store gained bus");
  chk_line_released: assert property (
    (q.rx != R_IDLE) |-> !padOe)
    else $error("line driven while receiving");
  chk_sleep_refuse: assert property (
    (q.acc == A_IDLE && q.accReq && cpuClkOff)
    |=> !busReq ##1 (q.dec == D_ERR && errSig == ERR_BUS))
    else $error("bus access not refused in sleep");
  chk_pad_ctrl: assert property (
    (resetPinFuse == FUSE_DEBUG)
    |=> (padPullUpEn && padInputEn && !resetFuncEn))
    else $error("pad not taken over by port");
  chk_clk_default: assert property (
    $rose(portActive) |-> physClkSel == CLKSEL_DEFAULT)
    else $error("clock not at default after enable");
  chk_clk_hold: assert property (
    (q.active && !(csWrite && q.fld == CS_CTRL)) |=> $stable(physClkSel))
    else $error("clock select changed without write");
  chk_one_req: assert property (
    (busReq && !busGrant) |=> (busReq && $stable(busAddr)))
    else $error("bus request dropped before grant");
  chk_break_reset: assert property (
    brk |=> (q.dec == D_SYNC && q.rx == R_IDLE && !q.accReq))
    else $error("break did not reset port");
  chk_tx_frame: assert property (
    (!q.txBusy && fifoOutValid && fifoOutReady)
    |=> (!(^q.txSh[9:1]) && q.txSh[11:10] == 2'b11 && !padOut && padOe))
    else $error("transmit frame malformed");
endmodule

// >>> tb/sdp_debugger.sv
// partner model: external debugger on the shared debug wire
`timescale 1ns/1ps
module sdp_debugger #(
  parameter int BT = 32
) (
  input wire logic sys_clk,
  input wire logic padOe,
  input wire logic padOut,
  output logic lineLvl,
  output logic dbgOe,
  output logic gotValid,
  output logic gotOk,
  output logic [7:0] gotData
);
  logic dbgVal;
  logic [11:0] rxBits;
  // a released line floats up to the pull-up level
  assign lineLvl = padOe ? padOut : (dbgOe ? dbgVal : 1'b1);
  initial begin
    dbgOe = 1'b0;
    dbgVal = 1'b1;
  end
  // ----------------------------------------------------------------
  // transmit side
  // ----------------------------------------------------------------
  task automatic send_frame(input logic [7:0] d, input bit badPar);
    logic [11:0] fr;
    fr = {2'b11, (^d) ^ badPar, d, 1'b0};
    // last stop bit is left to the pull-up so a reply may follow at once
    for (int i = 0; i < 12; i++) begin
      @(posedge sys_clk);
      dbgOe <= i < 11;
      dbgVal <= fr[i];
      repeat (BT - 1) @(posedge sys_clk);
    end
    @(posedge sys_clk);
    dbgOe <= 1'b0;
    repeat (2 * BT) @(posedge sys_clk);
  endtask
  task automatic send_break();
    @(posedge sys_clk);
    dbgOe <= 1'b1;
    dbgVal <= 1'b0;
    repeat (14 * BT) @(posedge sys_clk);
    dbgOe <= 1'b0;
    repeat (4 * BT) @(posedge sys_clk);
  endtask
  // ----------------------------------------------------------------
  // receive side: samples each reply bit in its middle
  // ----------------------------------------------------------------
  initial begin
    gotValid = 1'b0;
    gotOk = 1'b0;
    gotData = 8'h0;
    forever begin
      @(negedge sys_clk);
      gotValid = 1'b0;
      if (padOe && !lineLvl) begin
        repeat (BT / 2 - 1) @(negedge sys_clk);
        for (int i = 0; i < 12; i++) begin
          rxBits[i] = lineLvl;
          if (i < 11)
            repeat (BT) @(negedge sys_clk);
        end
        while (padOe) @(negedge sys_clk);
        gotData = rxBits[8:1];
        gotOk = !rxBits[0] && !(^rxBits[9:1]) && (&rxBits[11:10]);
        gotValid = 1'b1;
      end
    end
  end
endmodule

// >>> tb/testbench.sv
// self-checking bench of the single-wire debug port
`timescale 1ns/1ps
module testbench;
  import sdp_pkg::*;
  localparam int BT = 32;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic padIn, padOut, padOe, padPullUpEn, padInputEn, resetFuncEn;
  logic hvPulse = 1'b0;
  logic [1:0] resetPinFuse = 2'h0;
  logic [1:0] physClkSel;
  logic portActive, busReq, busWe, crcStatus = 1'b0, sleepStatus = 1'b0;
  logic cpuClkOff = 1'b0, busGrant = 1'b0, evIn = 1'b0;
  logic [15:0] busAddr, cpuPc = 16'h0, cpuSp = 16'h0, expAddr;
  logic [7:0] busWdata, busRdata = 8'h0, ocdStatus = 8'h0;
  logic [7:0] nvmStatus = 8'h0, cpuSreg = 8'h0, gotData, expWd, rd;
  logic [3:0] cpuCtl;
  logic [2:0] errSig, errExp = 3'h0;
  logic [1:0] clkExp = CLKSEL_DEFAULT;
  logic gotValid, gotOk, dbgOe, expWe;
  logic [7:0] expQ[$];
  logic [3:0] ctlQ[$];
  int fail_count = 0, tests_run = 0, grantWait = 0, evCount = 0;

  always #25 sys_clk = ~sys_clk;

  sdp_port u_dut (.sys_clk(sys_clk), .rst(rst), .padIn(padIn),
    .padOut(padOut), .padOe(padOe), .padPullUpEn(padPullUpEn),
    .padInputEn(padInputEn), .resetFuncEn(resetFuncEn),
    .hvPulse(hvPulse), .resetPinFuse(resetPinFuse),
    .portActive(portActive), .physClkSel(physClkSel),
    .cpuClkOff(cpuClkOff), .busReq(busReq), .busWe(busWe),
    .busAddr(busAddr), .busWdata(busWdata), .busGrant(busGrant),
    .busRdata(busRdata), .cpuCtl(cpuCtl), .ocdStatus(ocdStatus),
    .nvmStatus(nvmStatus), .crcStatus(crcStatus),
    .sleepStatus(sleepStatus), .cpuPc(cpuPc), .cpuSp(cpuSp),
    .cpuSreg(cpuSreg), .errSig(errSig), .evIn(evIn));
  sdp_debugger #(.BT(BT)) u_dbg (.sys_clk(sys_clk), .padOe(padOe),
    .padOut(padOut), .lineLvl(padIn), .dbgOe(dbgOe),
    .gotValid(gotValid), .gotOk(gotOk), .gotData(gotData));

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic end_test(input string name);
    $display("test %s done", name);
  endtask
  // sync, n bytes from the top of w, then wait for every awaited reply
  task automatic xfer(input int n, input logic [31:0] w, input bit bad = 0);
    u_dbg.send_frame(8'h55, 1'b0);
    for (int i = 0; i < n; i++)
      u_dbg.send_frame(w[31 - 8 * i -: 8], bad && i == 0);
    for (int i = 0; i < 20000 && expQ.size() != 0; i++)
      @(posedge sys_clk);
    check(expQ.size(), 0);
    expQ.delete();
    repeat (2 * BT) @(posedge sys_clk);
  endtask
  function automatic logic [7:0] exp_cs(input int i);
    case (i)
      0: return {6'h0, clkExp};
      2: return ocdStatus;
      3: return nvmStatus;
      4: return {6'h0, crcStatus, sleepStatus};
      5: return cpuPc[7:0];
      6: return cpuPc[15:8];
      7: return cpuSp[7:0];
      8: return cpuSp[15:8];
      9: return cpuSreg;
      10: return {5'h0, errExp};
      11: return 8'(evCount);
      12: return 8'(evCount >> 8);
      default: return 8'h0;
    endcase
  endfunction
  // replies pass through the port's reply fifo in order
  task automatic fifo_test();
    int idx;
    for (int k = 0; k < 6; k++) begin
      idx = $urandom_range(2, 9);
      {ocdStatus, nvmStatus, cpuSreg} <= 24'($urandom);
      {cpuPc, cpuSp} <= $urandom;
      @(posedge sys_clk);
      expQ.push_back(exp_cs(idx));
      xfer(1, {OP_LDCS, 1'b0, 4'(idx), 24'h0});
    end
    @(negedge sys_clk);
    check({padOe, padOut, busReq}, 3'h2);
    check(errSig, ERR_FRAME);
    check(physClkSel, clkExp);
  endtask

  // ----------------------------------------------------------------
  // bus responder and result monitor
  // ----------------------------------------------------------------
  always @(posedge sys_clk) begin
    busGrant <= 1'b0;
    if (busReq && cpuClkOff)
      check(1, 0);
    if (busReq && !busGrant) begin
      if (grantWait != 0) begin
        grantWait <= grantWait - 1;
      end else begin
        rd = 8'($urandom);
        busGrant <= 1'b1;
        busRdata <= rd;
        grantWait <= $urandom_range(0, 4);
        check({busWe, busAddr, busWdata & {8{busWe}}},
              {expWe, expAddr, expWd & {8{expWe}}});
        if (!busWe)
          expQ.push_back(rd);
      end
    end
  end
  always @(posedge sys_clk) begin
    if (padOe && dbgOe)
      check(1, 0);
    if (gotValid)
      check({gotOk, gotData}, {1'b1, expQ.pop_front()});
    if (cpuCtl !== 4'h0)
      check(cpuCtl, ctlQ.pop_front());
  end

  initial begin
    repeat (90000) @(posedge sys_clk);
    fail_count++;
    finish_test();
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    void'($urandom(32'h2151));
    repeat (20) @(posedge sys_clk);
    rst <= 1'b0;
    @(negedge sys_clk);
    check({padOe, padOut, portActive, resetFuncEn}, 4'h5);
    check({physClkSel, errSig}, {CLKSEL_DEFAULT, 3'h0});
    end_test("reset");
    @(posedge sys_clk);
    resetPinFuse <= FUSE_DEBUG;
    {ocdStatus, nvmStatus, cpuSreg} <= 24'($urandom);
    {cpuPc, cpuSp} <= $urandom;
    {crcStatus, sleepStatus} <= 2'($urandom);
    repeat (3) @(posedge sys_clk);
    check({portActive, padPullUpEn, padInputEn, resetFuncEn}, 4'he);
    resetPinFuse <= 2'h0;
    repeat (3) @(posedge sys_clk);
    check(portActive, 1'b0);
    hvPulse <= 1'b1;
    @(posedge sys_clk);
    hvPulse <= 1'b0;
    repeat (3) @(posedge sys_clk);
    check({portActive, resetFuncEn}, 2'h2);
    end_test("enable");
    expWe = 1'b1;
    {expAddr, expWd} = 24'($urandom);
    expQ.push_back(ACK_CHAR);
    xfer(4, {OP_ST, 5'h0, expAddr, expWd});
    expWe = 1'b0;
    expAddr = 16'($urandom);
    xfer(3, {OP_LD, 5'h0, expAddr, 8'h0});
    end_test("bus");
    evCount = $urandom_range(3, 20);
    repeat (evCount) begin
      @(posedge sys_clk) evIn <= 1'b1;
      @(posedge sys_clk) evIn <= 1'b0;
    end
    clkExp = 2'h1;
    xfer(2, {OP_STCS, 1'b0, CS_CTRL, 8'h01, 16'h0});
    check(physClkSel, clkExp);
    for (int i = 0; i < 14; i++) begin
      if (i == 1)
        continue;
      expQ.push_back(exp_cs(i));
      xfer(1, {OP_LDCS, 1'b0, 4'(i), 24'h0});
    end
    for (int i = 0; i < 4; i++) begin
      ctlQ.push_back(4'h1 << i);
      xfer(2, {OP_STCS, 1'b0, CS_FLOW, 8'h1 << i, 16'h0});
    end
    end_test("status");
    cpuClkOff <= 1'b1;
    xfer(4, {OP_ST, 5'h0, 24'($urandom)});
    check(errSig, ERR_BUS);
    cpuClkOff <= 1'b0;
    u_dbg.send_break();
    // the break's own low frame has bad stops and is kept as a frame error
    errExp = ERR_FRAME;
    expQ.push_back(exp_cs(10));
    xfer(1, {OP_LDCS, 1'b0, CS_ERR, 24'h0});
    for (int i = 0; i < 2; i++) begin
      xfer(1, i ? 32'h8000_0000 : {OP_LDCS, 1'b0, CS_SYS, 24'h0}, i == 0);
      check(errSig, i ? ERR_OPCODE : ERR_PARITY);
      u_dbg.send_break();
      expAddr = 16'($urandom);
      xfer(3, {OP_LD, 5'h0, expAddr, 8'h0});
    end
    end_test("errors");
    fifo_test();
    end_test("fifo");
    rst <= 1'b1;
    @(posedge sys_clk);
    rst <= 1'b0;
    @(negedge sys_clk);
    check({physClkSel, portActive}, {CLKSEL_DEFAULT, 1'b0});
    end_test("rereset");
    finish_test();
  end
endmodule
